// [rtl/dual_fifo_pkg.sv]
// Shared constants and types for the two-way queue port logic
package dual_fifo_pkg;
   localparam int DATA_W = 36;
   localparam int DEPTH = 256;
   localparam int PTR_W = 8;
   localparam int CNT_W = 9;
   localparam int PORTS = 2;
   // Bundle of one port's pin inputs, as carried through the synchroniser
   localparam int IN_W = DATA_W + 4;
   localparam int IN_CLK = DATA_W + 3;
   localparam int IN_SEL_N = DATA_W + 2;
   localparam int IN_EN = DATA_W + 1;
   localparam int IN_WR = DATA_W;
   localparam logic [CNT_W-1:0] FULL_COUNT = 9'h100;
   localparam logic [CNT_W-1:0] EMPTY_COUNT = 9'h000;
   localparam logic [CNT_W-1:0] PTR_RST = 9'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
   localparam logic [IN_W-1:0] PIN_RST = 40'h40_0000_0000;
   typedef enum logic {
      MODE_FALL_THROUGH = 1'b0,
      MODE_STANDARD = 1'b1
   } timing_mode_type;
   localparam timing_mode_type MODE_RST = MODE_STANDARD;
endpackage : dual_fifo_pkg

// [rtl/dual_fifo_queue.sv]
// One queue: storage array with write and read pointers
`timescale 1ns/100ps
module dual_fifo_queue (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_push,
   input wire logic [dual_fifo_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_pop,
   output logic [dual_fifo_pkg::DATA_W-1:0] o_rdata,
   output logic [dual_fifo_pkg::CNT_W-1:0] o_count
);
   import dual_fifo_pkg::*;

   logic [DATA_W-1:0] mem [DEPTH];
   logic [CNT_W-1:0] wr_ptr;
   logic [CNT_W-1:0] rd_ptr;
   logic [CNT_W-1:0] next_wr_ptr;
   logic [CNT_W-1:0] next_rd_ptr;

   // Caller guards push against full and pop against empty
   always_comb begin
      next_wr_ptr = wr_ptr + CNT_W'(i_push);
      next_rd_ptr = rd_ptr + CNT_W'(i_pop);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wr_ptr <= PTR_RST;
         rd_ptr <= PTR_RST;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage holds no reset, so it maps onto plain RAM
   always_ff @(posedge i_clk) begin
      if (i_push) begin
         mem[wr_ptr[PTR_W-1:0]] <= i_wdata;
      end
   end

   assign o_rdata = mem[rd_ptr[PTR_W-1:0]];
   assign o_count = wr_ptr - rd_ptr;
endmodule : dual_fifo_queue

// [rtl/dual_port_fifo_access_flags.sv]
// Port access control and flags for a two-way queue pair, ports A and B
// Behaviour
// - Port A transfers happen only on rising edges of the port A clock.
// - Port B transfers happen only on rising edges of the port B clock.
// - Port A flags change only on port A clock rising edges.
// - Port B flags change only on port B clock rising edges.
// - Port A transfers need port A select low.
// - Port A data lines released while port A select is high.
// - Port B transfers need port B select low.
// - Port B data lines released while port B select is high.
// - Port A transfers need port A enable high.
// - Port B transfers need port B enable high.
// - Standard mode: port A empty pin shows B-to-A queue empty.
// - Fall-through mode: port A pin shows valid B-to-A word on lines.
// - Standard mode: port B empty pin shows A-to-B queue empty.
// - Fall-through mode: port B pin shows valid A-to-B word on lines.
// - Standard mode: port A full pin shows A-to-B queue full.
// - Fall-through mode: port A pin shows space in A-to-B queue.
// - Standard mode: port B full pin shows B-to-A queue full.
// - Fall-through mode: port B pin shows space in B-to-A queue.
// - Timing mode taken at reset: high standard, low fall-through; held static.
// - Port A almost-empty low when B-to-A count at or below offset.
`timescale 1ns/100ps
module dual_port_fifo_access_flags (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_port_a_clock,
   input wire logic i_port_a_select_n,
   input wire logic i_port_a_xfer_enable,
   input wire logic i_port_a_write,
   input wire logic [dual_fifo_pkg::DATA_W-1:0] i_port_a_data,
   output logic [dual_fifo_pkg::DATA_W-1:0] o_port_a_data,
   output logic o_port_a_data_oe_n,
   output logic o_port_a_empty_flag_n,
   output logic o_port_a_full_flag_n,
   output logic o_port_a_almost_empty_n,
   input wire logic i_port_b_clock,
   input wire logic i_port_b_select_n,
   input wire logic i_port_b_xfer_enable,
   input wire logic i_port_b_write,
   input wire logic [dual_fifo_pkg::DATA_W-1:0] i_port_b_data,
   output logic [dual_fifo_pkg::DATA_W-1:0] o_port_b_data,
   output logic o_port_b_data_oe_n,
   output logic o_port_b_empty_flag_n,
   output logic o_port_b_full_flag_n,
   input wire logic i_endian_timing_select,
   input wire logic [dual_fifo_pkg::CNT_W-1:0] i_a_almost_empty_offset
);
   import dual_fifo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; index 0 is port A, index 1 is port B
   logic [IN_W-1:0] pin_in [PORTS];
   logic [IN_W-1:0] sync1 [PORTS];
   logic [IN_W-1:0] sync2 [PORTS];
   logic [PORTS-1:0] clk_prev;
   logic ets_s1;
   logic ets_s2;
   logic [CNT_W-1:0] off_s1;
   logic [CNT_W-1:0] off_s2;

   assign pin_in[0] = {i_port_a_clock, i_port_a_select_n, i_port_a_xfer_enable,
                       i_port_a_write, i_port_a_data};
   assign pin_in[1] = {i_port_b_clock, i_port_b_select_n, i_port_b_xfer_enable,
                       i_port_b_write, i_port_b_data};

   // All fields share one depth so data stays aligned with its clock edge
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         for (int i = 0; i < PORTS; i++) begin
            sync1[i] <= PIN_RST;
            sync2[i] <= PIN_RST;
            clk_prev[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < PORTS; i++) begin
            sync1[i] <= pin_in[i];
            sync2[i] <= sync1[i];
            clk_prev[i] <= sync2[i][IN_CLK];
         end
      end
   end

   // Left out of reset so the mode pin is already sampled while reset is held
   always_ff @(posedge i_clk) begin
      ets_s1 <= i_endian_timing_select;
      ets_s2 <= ets_s1;
      off_s1 <= i_a_almost_empty_offset;
      off_s2 <= off_s1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timing mode
   timing_mode_type mode;
   timing_mode_type next_mode;

   always_comb begin
      next_mode = mode;
      if (!i_rstn) begin
         next_mode = timing_mode_type'(ets_s2);
      end
   end

   always_ff @(posedge i_clk) begin
      mode <= next_mode;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port access; port p writes queue p and reads queue PORTS-1-p
   logic [PORTS-1:0] edge_w;
   logic [PORTS-1:0] push_q;
   logic [PORTS-1:0] pop_q;
   logic [CNT_W-1:0] count [PORTS];
   logic [CNT_W-1:0] cnt_next [PORTS];
   logic [DATA_W-1:0] rdata [PORTS];
   logic [DATA_W-1:0] out_data_w [PORTS];
   logic [PORTS-1:0] oe_n_w;
   logic [PORTS-1:0] empty_n_w;
   logic [PORTS-1:0] full_n_w;
   logic [PORTS-1:0] valid_w;

   for (genvar p = 0; p < PORTS; p++) begin : g_port
      localparam int RQ = PORTS - 1 - p;
      logic xfer;
      logic take_wr;
      logic take_rd;
      logic load;
      logic [DATA_W-1:0] out_data;
      logic out_valid;
      logic oe_n;
      logic empty_n;
      logic full_n;
      logic [DATA_W-1:0] next_out_data;
      logic next_out_valid;
      logic next_oe_n;
      logic next_empty_n;
      logic next_full_n;

      dual_fifo_queue u_queue (
         .i_clk(i_clk),
         .i_rstn(i_rstn),
         .i_push(push_q[p]),
         .i_wdata(sync2[p][DATA_W-1:0]),
         .i_pop(pop_q[p]),
         .o_rdata(rdata[p]),
         .o_count(count[p])
      );

      // Port clock edge found on synchronised copy
      assign edge_w[p] = sync2[p][IN_CLK] & ~clk_prev[p];
      // Select low and enable high qualify the edge
      assign xfer = edge_w[p] & ~sync2[p][IN_SEL_N] & sync2[p][IN_EN];
      assign take_wr = xfer & sync2[p][IN_WR];
      assign take_rd = xfer & ~sync2[p][IN_WR];
      assign push_q[p] = take_wr & (count[p] != FULL_COUNT);
      assign cnt_next[p] = count[p] + CNT_W'(push_q[p]) - CNT_W'(pop_q[p]);

      // Output register loads only from a non-empty queue
      always_comb begin
         load = 1'b0;
         if (count[RQ] != EMPTY_COUNT) begin
            if (mode == MODE_STANDARD) begin
               load = take_rd;
            end else begin
               load = edge_w[p] & (~out_valid | take_rd);
            end
         end
      end
      assign pop_q[RQ] = load;

      always_comb begin
         next_out_data = out_data;
         next_out_valid = out_valid;
         next_empty_n = empty_n;
         next_full_n = full_n;
         // Drive only while selected for a read
         next_oe_n = sync2[p][IN_SEL_N] | sync2[p][IN_WR];
         if (load) begin
            next_out_data = rdata[RQ];
         end
         // Flags move on this port's clock edges only
         if (edge_w[p]) begin
            // Word on lines stays valid until read
            next_out_valid = load | (out_valid & ~take_rd);
            if (mode == MODE_STANDARD) begin
               next_empty_n = cnt_next[RQ] != EMPTY_COUNT;
            end else begin
               next_empty_n = load | (out_valid & ~take_rd);
            end
            // Both modes show space with the same logic and timing
            next_full_n = cnt_next[p] != FULL_COUNT;
         end
      end

      always_ff @(posedge i_clk) begin
         if (!i_rstn) begin
            out_data <= DATA_RST;
            out_valid <= 1'b0;
            oe_n <= 1'b1;
            empty_n <= 1'b0;
            full_n <= 1'b1;
         end else begin
            out_data <= next_out_data;
            out_valid <= next_out_valid;
            oe_n <= next_oe_n;
            empty_n <= next_empty_n;
            full_n <= next_full_n;
         end
      end

      assign out_data_w[p] = out_data;
      assign valid_w[p] = out_valid;
      assign oe_n_w[p] = oe_n;
      assign empty_n_w[p] = empty_n;
      assign full_n_w[p] = full_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port A almost-empty
   logic ae_n;
   logic next_ae_n;

   // Low at or below offset, sampled on port A edges
   always_comb begin
      next_ae_n = ae_n;
      if (edge_w[0]) begin
         next_ae_n = cnt_next[1] > off_s2;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ae_n <= 1'b0;
      end else begin
         ae_n <= next_ae_n;
      end
   end

   assign o_port_a_data = out_data_w[0];
   assign o_port_a_data_oe_n = oe_n_w[0];
   assign o_port_a_empty_flag_n = empty_n_w[0];
   assign o_port_a_full_flag_n = full_n_w[0];
   assign o_port_a_almost_empty_n = ae_n;
   assign o_port_b_data = out_data_w[1];
   assign o_port_b_data_oe_n = oe_n_w[1];
   assign o_port_b_empty_flag_n = empty_n_w[1];
   assign o_port_b_full_flag_n = full_n_w[1];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_clk_sync_a: assert property (push_q[0] || pop_q[1] |-> edge_w[0])
      else $error("port A transfer off its clock edge");
   b_clk_sync_a: assert property (push_q[1] || pop_q[0] |-> edge_w[1])
      else $error("port B transfer off its clock edge");
   a_flag_hold_a: assert property (!edge_w[0] |=> $stable(empty_n_w[0])
      && $stable(full_n_w[0]) && $stable(ae_n))
      else $error("port A flag moved without a port A edge");
   b_flag_hold_a: assert property (!edge_w[1] |=> $stable(empty_n_w[1])
      && $stable(full_n_w[1]))
      else $error("port B flag moved without a port B edge");
   a_select_a: assert property (push_q[0] |-> !sync2[0][IN_SEL_N])
      else $error("port A write while deselected");
   a_release_a: assert property (sync2[0][IN_SEL_N] |=> o_port_a_data_oe_n)
      else $error("port A lines driven while deselected");
   b_select_a: assert property (push_q[1] |-> !sync2[1][IN_SEL_N])
      else $error("port B write while deselected");
   b_release_a: assert property (sync2[1][IN_SEL_N] |=> o_port_b_data_oe_n)
      else $error("port B lines driven while deselected");
   a_enable_a: assert property (push_q[0] |-> sync2[0][IN_EN])
      else $error("port A write while disabled");
   b_enable_a: assert property (push_q[1] |-> sync2[1][IN_EN])
      else $error("port B write while disabled");
   a_std_empty_a: assert property (mode == MODE_STANDARD && edge_w[0]
      |=> empty_n_w[0] == (count[1] != EMPTY_COUNT))
      else $error("port A empty flag wrong");
   a_ready_a: assert property (mode == MODE_FALL_THROUGH && edge_w[0]
      |=> empty_n_w[0] == valid_w[0])
      else $error("port A output ready wrong");
   b_std_empty_a: assert property (mode == MODE_STANDARD && edge_w[1]
      |=> empty_n_w[1] == (count[0] != EMPTY_COUNT))
      else $error("port B empty flag wrong");
   b_ready_a: assert property (mode == MODE_FALL_THROUGH && edge_w[1]
      |=> empty_n_w[1] == valid_w[1])
      else $error("port B output ready wrong");
   a_full_flag_a: assert property (edge_w[0]
      |=> full_n_w[0] == (count[0] != FULL_COUNT))
      else $error("port A full flag wrong");
   b_full_flag_a: assert property (edge_w[1]
      |=> full_n_w[1] == (count[1] != FULL_COUNT))
      else $error("port B full flag wrong");
   mode_static_a: assert property (i_rstn && $past(i_rstn) |-> $stable(mode))
      else $error("timing mode changed in operation");
   a_almost_a: assert property (edge_w[0] |=> ae_n == (count[1] > off_s2))
      else $error("port A almost-empty wrong");
   no_overrun_a: assert property (push_q[0] |-> count[0] != FULL_COUNT)
      else $error("write into full queue");
   no_underrun_a: assert property (pop_q[1] |-> count[1] != EMPTY_COUNT)
      else $error("read from empty queue");

   a_full_c: cover property (full_n_w[0] == 1'b0);
   ft_read_c: cover property (mode == MODE_FALL_THROUGH && pop_q[0] && valid_w[1]);
   std_read_c: cover property (mode == MODE_STANDARD && pop_q[1]);
   both_push_c: cover property (push_q[0] && push_q[1]);
endmodule : dual_port_fifo_access_flags

// [bench/port_host.sv]
// Host model for one port: port clock and transfer strobes
`timescale 1ns/100ps
module port_host (
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic [dual_fifo_pkg::DATA_W-1:0] i_data,
   input wire logic i_oe_n,
   input wire logic i_empty_n,
   input wire logic i_full_n,
   output logic o_port_clock,
   output logic o_select_n,
   output logic o_xfer_enable,
   output logic o_write,
   output logic [dual_fifo_pkg::DATA_W-1:0] o_data
);
   import dual_fifo_pkg::*;
   int phase = 0;
   initial begin
      o_port_clock = 1'b0;
      o_select_n = 1'b1;
      o_xfer_enable = 1'b0;
      o_write = 1'b0;
      o_data = 36'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Ten system cycles a period; still while stopped, so no stray edge
   always @(negedge i_clk) begin
      phase <= i_run ? (phase + 1) % 10 : 0;
      o_port_clock <= i_run && ((phase + 1) % 10 >= 5);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Strobes held over one whole port edge
   task automatic xfer(input logic cs_n, input logic en, input logic wr,
         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
         output logic [2:0] flags);
      @(negedge i_clk iff (phase == 1));
      o_select_n = cs_n;
      o_xfer_enable = en;
      o_write = wr;
      o_data = wr ? d : ~o_data;
      @(negedge o_port_clock);
      q = i_data;
      flags = {i_oe_n, i_empty_n, i_full_n};
      // Released lines toggle so a stale word never looks fresh
      o_select_n = 1'b1;
      o_xfer_enable = 1'b0;
      o_data = ~o_data;
   endtask : xfer
endmodule : port_host

// [bench/testbench.sv]
// Self-checking bench: both ports driven by host models
`timescale 1ns/100ps
module testbench;
   import dual_fifo_pkg::*;
   localparam logic [DATA_W-1:0] BASE = 36'h1_2345_6000;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic run = 1'b0;
   logic mode = 1'b1;
   logic [CNT_W-1:0] offset = 9'h002;
   logic a_clk, a_sel_n, a_en, a_wr, a_oe_n, a_ef_n, a_ff_n, a_ae_n;
   logic b_clk, b_sel_n, b_en, b_wr, b_oe_n, b_ef_n, b_ff_n;
   logic [DATA_W-1:0] a_wd, a_rd, b_wd, b_rd, q;
   logic [2:0] fl;
   int err_total = 0;
   int compares = 0;
   initial forever #4 i_clk = ~i_clk;
   dual_port_fifo_access_flags i_dual_port_fifo_access_flags (.i_clk(i_clk),
      .i_rstn(i_rstn), .i_port_a_clock(a_clk), .i_port_a_select_n(a_sel_n),
      .i_port_a_xfer_enable(a_en), .i_port_a_write(a_wr), .i_port_a_data(a_wd),
      .o_port_a_data(a_rd), .o_port_a_data_oe_n(a_oe_n), .o_port_a_empty_flag_n(a_ef_n),
      .o_port_a_full_flag_n(a_ff_n), .o_port_a_almost_empty_n(a_ae_n),
      .i_port_b_clock(b_clk), .i_port_b_select_n(b_sel_n), .i_port_b_xfer_enable(b_en),
      .i_port_b_write(b_wr), .i_port_b_data(b_wd), .o_port_b_data(b_rd),
      .o_port_b_data_oe_n(b_oe_n), .o_port_b_empty_flag_n(b_ef_n),
      .o_port_b_full_flag_n(b_ff_n), .i_endian_timing_select(mode),
      .i_a_almost_empty_offset(offset));
   port_host i_port_host_a (.i_clk(i_clk), .i_run(run), .i_data(a_rd), .i_oe_n(a_oe_n),
      .i_empty_n(a_ef_n), .i_full_n(a_ff_n), .o_port_clock(a_clk), .o_select_n(a_sel_n),
      .o_xfer_enable(a_en), .o_write(a_wr), .o_data(a_wd));
   port_host i_port_host_b (.i_clk(i_clk), .i_run(run), .i_data(b_rd), .i_oe_n(b_oe_n),
      .i_empty_n(b_ef_n), .i_full_n(b_ff_n), .o_port_clock(b_clk), .o_select_n(b_sel_n),
      .o_xfer_enable(b_en), .o_write(b_wr), .o_data(b_wd));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input string what, input logic [DATA_W-1:0] exp,
         input logic [DATA_W-1:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_flag(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_flag
   task automatic give_verdict();
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic px(input bit p, input logic cs_n, input logic en, input logic wr,
         input logic [DATA_W-1:0] d);
      if (p) begin
         i_port_host_b.xfer(cs_n, en, wr, d, q, fl);
      end else begin
         i_port_host_a.xfer(cs_n, en, wr, d, q, fl);
      end
   endtask : px
   // Mode level set with reset and held static after it
   task automatic do_reset(input logic m);
      @(negedge i_clk);
      run <= 1'b0;
      i_rstn <= 1'b0;
      mode <= m;
      repeat (12) @(negedge i_clk);
      i_rstn <= 1'b1;
      @(negedge i_clk);
      run <= 1'b1;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////
   task automatic reset_state();
      chk_flag("a empty", 1'b0, a_ef_n);
      chk_flag("b empty", 1'b0, b_ef_n);
      chk_flag("a full", 1'b1, a_ff_n);
      chk_flag("b full", 1'b1, b_ff_n);
      chk_flag("a released", 1'b1, a_oe_n);
      chk_flag("b released", 1'b1, b_oe_n);
      chk_flag("a almost empty", 1'b0, a_ae_n);
   endtask : reset_state
   task automatic std_gating();
      for (int i = 0; i < 3; i++) px(0, 0, 1, 1, BASE + i);
      px(0, 1, 1, 1, 36'hB_AD00_0001);
      px(0, 0, 0, 1, 36'hB_AD00_0002);
      px(1, 1, 1, 0, 36'h0);
      chk_flag("b oe unselected", 1'b1, fl[2]);
      chk_flag("b not empty", 1'b1, fl[1]);
      px(1, 0, 0, 0, 36'h0);
      for (int i = 0; i < 3; i++) begin
         px(1, 0, 1, 0, 36'h0);
         chk_word("b read", BASE + i, q);
         chk_flag("b oe read", 1'b0, fl[2]);
      end
      chk_flag("b empty end", 1'b0, fl[1]);
      px(1, 0, 1, 0, 36'h0);
      chk_word("b read empty", BASE + 2, q);
   endtask : std_gating
   task automatic fill_drain(input bit p);
      for (int i = 0; i < DEPTH; i++) begin
         px(p, 0, 1, 1, DATA_W'(i));
         if (i == DEPTH - 2) chk_flag("space left", 1'b1, fl[0]);
      end
      chk_flag("full", 1'b0, fl[0]);
      px(p, 0, 1, 1, 36'hF_0000_0000);
      for (int i = 0; i < DEPTH; i++) begin
         px(!p, 0, 1, 0, 36'h0);
         chk_word("drain", DATA_W'(i), q);
      end
      chk_flag("drained", 1'b0, fl[1]);
   endtask : fill_drain
   task automatic almost_empty();
      for (int i = 0; i < 3; i++) px(1, 0, 1, 1, BASE + 8 + i);
      px(0, 0, 0, 0, 36'h0);
      chk_flag("a almost empty 3", 1'b1, a_ae_n);
      chk_flag("a empty 3", 1'b1, fl[1]);
      px(0, 0, 1, 0, 36'h0);
      chk_word("a read", BASE + 8, q);
      chk_flag("a oe read", 1'b0, fl[2]);
      chk_flag("a almost empty 2", 1'b0, a_ae_n);
      px(0, 0, 1, 0, 36'h0);
      px(0, 0, 1, 0, 36'h0);
      chk_word("a read last", BASE + 10, q);
      chk_flag("a empty 0", 1'b0, fl[1]);
   endtask : almost_empty
   task automatic fall_through();
      do_reset(1'b0);
      px(0, 0, 1, 1, BASE + 20);
      px(0, 0, 1, 1, BASE + 21);
      chk_flag("a input ready", 1'b1, fl[0]);
      px(1, 0, 0, 0, 36'h0);
      chk_word("b head shown", BASE + 20, q);
      chk_flag("b output ready", 1'b1, fl[1]);
      px(1, 0, 1, 0, 36'h0);
      chk_word("b refilled", BASE + 21, q);
      px(1, 0, 1, 0, 36'h0);
      chk_flag("b drained", 1'b0, fl[1]);
      chk_flag("b input ready", 1'b1, fl[0]);
      px(1, 0, 1, 1, BASE + 22);
      px(0, 0, 0, 0, 36'h0);
      chk_word("a head shown", BASE + 22, q);
      chk_flag("a output ready", 1'b1, fl[1]);
   endtask : fall_through
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b1);
      reset_state();
      std_gating();
      fill_drain(1'b0);
      fill_drain(1'b1);
      almost_empty();
      fall_through();
      give_verdict();
   end
   // Run needs about 11000 cycles; near three times that means a hang
   initial begin
      repeat (30000) @(posedge i_clk);
      err_total++;
      give_verdict();
   end
endmodule : testbench
